// ===== hw/lcd_seq_pkg.sv
package lcd_seq_pkg;

  // clock rate and documented sequence timing
  localparam int CLK_MHZ      = 50;
  localparam int RELEASE_US   = 10;
  localparam int RELEASE_CYC  = RELEASE_US * CLK_MHZ;
  localparam int OFF_MS       = 50;
  localparam int OFF_CYC      = OFF_MS * 1000 * CLK_MHZ;
  localparam int TIMER_W      = 22;

  // command write strobe shape, least times rounded up to whole cycles
  localparam int WR_SETUP_NS  = 20;
  localparam int WR_LOW_NS    = 80;
  localparam int WR_HOLD_NS   = 40;
  localparam int WR_SETUP_CYC = (WR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_LOW_CYC   = (WR_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_HOLD_CYC  = (WR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int PH_W         = 4;

  // register byte offsets on the wishbone slave
  localparam logic [3:0] ADR_CTRL     = 4'h0;
  localparam logic [3:0] ADR_CONTRAST = 4'h4;
  localparam logic [3:0] ADR_STATUS   = 4'h8;
  localparam logic [3:0] ADR_RAW      = 4'hc;

  // field positions
  localparam int CTRL_INIT_BIT   = 0;
  localparam int CTRL_SHUT_BIT   = 1;
  localparam int CTRL_BOOST5_BIT = 2;
  localparam int ST_INIT_DONE    = 0;
  localparam int ST_OFF_DONE     = 1;
  localparam int ST_BUSY         = 2;
  localparam int ST_REFUSED      = 3;
  localparam int ST_POWER_GOOD   = 4;
  localparam int ST_STEP_LSB     = 8;
  localparam int RAW_SEL_BIT     = 8;

  // reset values
  localparam logic [5:0] CONTRAST_RST = 6'h1b;
  localparam logic       BOOST5_RST   = 1'b0;

  // command bytes
  localparam logic [7:0] CMD_BIAS_1_9    = 8'ha2;
  localparam logic [7:0] CMD_SEG_NORMAL  = 8'ha0;
  localparam logic [7:0] CMD_COM_REVERSE = 8'hc8;
  localparam logic [7:0] CMD_BOOST_MODE  = 8'hf8;
  localparam logic [7:0] CMD_BOOST_4X    = 8'h00;
  localparam logic [7:0] CMD_BOOST_5X    = 8'h01;
  localparam logic [7:0] CMD_REG_RATIO   = 8'h25;
  localparam logic [7:0] CMD_VOL_MODE    = 8'h81;
  localparam logic [7:0] CMD_PWR_BOOST   = 8'h2c;
  localparam logic [7:0] CMD_PWR_REG     = 8'h2e;
  localparam logic [7:0] CMD_PWR_FOLLOW  = 8'h2f;
  localparam logic [7:0] CMD_DISP_ON     = 8'haf;
  localparam logic [7:0] CMD_DISP_OFF    = 8'hae;
  localparam logic [7:0] CMD_ALL_ON      = 8'ha5;

  localparam logic [3:0] INIT_LAST = 4'hb;
  localparam logic [3:0] SHUT_LAST = 4'h1;

  // pins toward the module's command port
  typedef struct packed {
    logic       chip_clear_n;
    logic       cmd_data_sel;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [7:0] data;
    logic       data_oe;
  } lcd_pins_t;

endpackage : lcd_seq_pkg

// ===== hw/lcd_wait_timer.sv
`timescale 1ns/1ps
// down counter: done_o pulses once when a loaded wait has run out
module lcd_wait_timer
  import lcd_seq_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              done_o
);

  logic [W-1:0] cnt_ff;
  logic         run_ff;

  // count down to one, then flag the end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      if (load_i) begin
        cnt_ff <= count_i;
        run_ff <= 1'b1;
      end else if (run_ff) begin
        if (cnt_ff <= W'(1)) begin
          run_ff <= 1'b0;
          done_o <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - W'(1);
        end
      end
    end
  end

endmodule : lcd_wait_timer

// ===== hw/lcd_byte_writer.sv
`timescale 1ns/1ps
// one parallel write cycle: setup, write strobe low, hold
module lcd_byte_writer
  import lcd_seq_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       start_i,
  input  wire logic       dsel_i,
  input  wire logic [7:0] byte_i,
  output logic            busy_o,
  output logic            done_o,
  output logic            cmd_data_sel_o,
  output logic            cs_n_o,
  output logic            wr_n_o,
  output logic [7:0]      data_o,
  output logic            data_oe_o
);

  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_LOW, PH_HOLD} phase_t;

  phase_t          ph_ff;
  logic [PH_W-1:0] cnt_ff;

  assign busy_o = (ph_ff != PH_IDLE);

  // phase sequencing; read strobe never leaves high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_ff          <= PH_IDLE;
      cnt_ff         <= '0;
      done_o         <= 1'b0;
      cmd_data_sel_o <= 1'b0;
      cs_n_o         <= 1'b1;
      wr_n_o         <= 1'b1;
      data_o         <= 8'h00;
      data_oe_o      <= 1'b0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      unique case (ph_ff)
        PH_IDLE: begin
          if (start_i) begin
            cmd_data_sel_o <= dsel_i;  // RULE13
            data_o         <= byte_i;
            data_oe_o      <= 1'b1;
            cs_n_o         <= 1'b0;
            cnt_ff         <= PH_W'(WR_SETUP_CYC);
            ph_ff          <= PH_SETUP;
          end
        end
        PH_SETUP: begin
          if (cnt_ff <= PH_W'(1)) begin
            wr_n_o <= 1'b0;  // RULE13
            cnt_ff <= PH_W'(WR_LOW_CYC);
            ph_ff  <= PH_LOW;
          end else begin
            cnt_ff <= cnt_ff - PH_W'(1);
          end
        end
        PH_LOW: begin
          if (cnt_ff <= PH_W'(1)) begin
            wr_n_o <= 1'b1;
            cnt_ff <= PH_W'(WR_HOLD_CYC);
            ph_ff  <= PH_HOLD;
          end else begin
            cnt_ff <= cnt_ff - PH_W'(1);
          end
        end
        PH_HOLD: begin
          if (cnt_ff <= PH_W'(1)) begin
            cs_n_o    <= 1'b1;
            data_oe_o <= 1'b0;
            done_o    <= 1'b1;
            ph_ff     <= PH_IDLE;
          end else begin
            cnt_ff <= cnt_ff - PH_W'(1);
          end
        end
      endcase
    end
  end

endmodule : lcd_byte_writer

// ===== hw/lcd_power_init_sequencer.sv
`timescale 1ns/1ps
// Operation
// RULE1 - hold chip clear low until supply good
// RULE2 - wait 10 us after release
// RULE3 - first command selects 1/9 bias
// RULE4 - then normal segment order
// RULE5 - then reverse common scan
// RULE6 - then booster ratio pair, 4x or 5x
// RULE7 - then regulator ratio byte
// RULE8 - then contrast mode and level bytes
// RULE9 - contrast level adjustable by software
// RULE10 - power circuits one by one, display on
// RULE11 - shutdown sends display off, all on
// RULE12 - then chip clear low, wait 50 ms
// RULE13 - every byte is a command write; raw writes in ready can set data select from RAW bit 8
// RULE14 - device takes power enables from low bits
// RULE15 - device accepts contrast level 0 to 63
// RULE16 - strict order, no data before on
// RULE17 - report init done and shutdown done
module lcd_power_init_sequencer
  import lcd_seq_pkg::*;
#(
  parameter int OFF_WAIT_CYC = OFF_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        power_good_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output lcd_pins_t        lcd_o,
  output logic             init_done_o,
  output logic             off_done_o
);
  typedef enum logic [3:0] {S_OFF, S_REL_WAIT, S_INIT_SEND, S_INIT_WAIT, S_READY, S_RAW_WAIT,
                            S_SHUT_SEND, S_SHUT_WAIT, S_OFF_WAIT, S_OFF_DONE} seq_state_t;
  seq_state_t   state_ff;
  logic [3:0]   step_ff;
  logic         clear_n_ff;
  logic         pg_meta_ff;
  logic         pg_sync_ff;
  logic         init_req_ff;
  logic         shut_req_ff;
  logic         raw_req_ff;
  logic         raw_sel_ff;
  logic [7:0]   raw_byte_ff;
  logic         boost5_ff;
  logic [5:0]   contrast_ff;
  logic         refused_ff;
  logic         init_done_ff;
  logic         off_done_ff;
  logic         ack_ff;
  logic [31:0]  rd_data_ff;
  logic         wr_start;
  logic         wr_dsel;
  logic [7:0]   wr_byte;
  logic         wr_busy;
  logic         wr_done;
  logic         tmr_load;
  logic [TIMER_W-1:0] tmr_count;
  logic         tmr_done;
  logic         wb_req;
  logic         wb_wr;
  logic         init_take;
  logic         shut_take;
  logic         raw_take;
  logic         init_ok;
  logic         shut_ok;
  logic         raw_ok;
  // init command byte for a given step
  function automatic logic [7:0] init_byte(input logic [3:0] step, input logic boost5,
                                           input logic [5:0] level);
    logic [7:0] b;
    unique case (step)
      4'h0: b = CMD_BIAS_1_9;                               // RULE3
      4'h1: b = CMD_SEG_NORMAL;                             // RULE4
      4'h2: b = CMD_COM_REVERSE;                            // RULE5
      4'h3: b = CMD_BOOST_MODE;                             // RULE6
      4'h4: b = boost5 ? CMD_BOOST_5X : CMD_BOOST_4X;       // RULE6
      4'h5: b = CMD_REG_RATIO;                              // RULE7
      4'h6: b = CMD_VOL_MODE;                               // RULE8
      4'h7: b = {2'b00, level};                             // RULE8 RULE9
      4'h8: b = CMD_PWR_BOOST;                              // RULE10
      4'h9: b = CMD_PWR_REG;                                // RULE10
      4'ha: b = CMD_PWR_FOLLOW;                             // RULE10
      4'hb: b = CMD_DISP_ON;                                // RULE10
      default: b = CMD_BIAS_1_9;
    endcase
    return b;
  endfunction : init_byte
  // register address match, used by read and write decode
  function automatic logic adr_is(input logic [3:0] adr, input logic [3:0] ref_adr);
    return adr == ref_adr;
  endfunction : adr_is
  // wishbone request and the edge at which a write takes effect
  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr  = wb_req & wb_we_i & ack_ff;
  // requests are accepted only in states where they make sense
  assign init_ok = (state_ff == S_OFF) || (state_ff == S_OFF_DONE);
  assign shut_ok = (state_ff == S_READY) || (state_ff == S_RAW_WAIT);
  assign raw_ok  = (state_ff == S_READY) && !raw_req_ff;  // RULE16
  assign init_take = (state_ff == S_OFF) && init_req_ff && pg_sync_ff;  // RULE1
  assign shut_take = (state_ff == S_READY) && shut_req_ff && !raw_req_ff;
  assign raw_take  = (state_ff == S_READY) && raw_req_ff;
  // power good pin crosses into the clock domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pg_meta_ff <= 1'b0;
      pg_sync_ff <= 1'b0;
    end else if (ce_i) begin
      pg_meta_ff <= power_good_i;
      pg_sync_ff <= pg_meta_ff;
    end
  end
  // wishbone slave handshake: one cycle ack, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= wb_req & ~ack_ff;
    end
  end
  assign wb_ack_o = ack_ff;
  // read data captured with the ack; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_ff <= 32'h0000_0000;
    end else if (ce_i && wb_req && !ack_ff) begin
      rd_data_ff <= 32'h0000_0000;
      if (adr_is(wb_adr_i, ADR_CTRL)) begin
        rd_data_ff[CTRL_INIT_BIT]   <= init_req_ff;
        rd_data_ff[CTRL_SHUT_BIT]   <= shut_req_ff;
        rd_data_ff[CTRL_BOOST5_BIT] <= boost5_ff;
      end else if (adr_is(wb_adr_i, ADR_CONTRAST)) begin
        rd_data_ff[5:0] <= contrast_ff;
      end else if (adr_is(wb_adr_i, ADR_STATUS)) begin
        rd_data_ff[ST_INIT_DONE]  <= init_done_ff;
        rd_data_ff[ST_OFF_DONE]   <= off_done_ff;
        rd_data_ff[ST_BUSY]       <= wr_busy | raw_req_ff;
        rd_data_ff[ST_REFUSED]    <= refused_ff;
        rd_data_ff[ST_POWER_GOOD] <= pg_sync_ff;
        rd_data_ff[ST_STEP_LSB +: 4] <= step_ff;
      end else if (adr_is(wb_adr_i, ADR_RAW)) begin
        rd_data_ff[RAW_SEL_BIT] <= raw_sel_ff;
        rd_data_ff[7:0]         <= raw_byte_ff;
      end
    end
  end
  assign wb_dat_o = rd_data_ff;
  // settings written by software
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boost5_ff   <= BOOST5_RST;
      contrast_ff <= CONTRAST_RST;
    end else if (ce_i && wb_wr && wb_sel_i[0]) begin
      if (adr_is(wb_adr_i, ADR_CTRL)) begin
        boost5_ff <= wb_dat_i[CTRL_BOOST5_BIT];
      end
      if (adr_is(wb_adr_i, ADR_CONTRAST)) begin
        contrast_ff <= wb_dat_i[5:0];  // RULE9
      end
    end
  end
  // pending init and shutdown requests; a new request wins over the take
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      init_req_ff <= 1'b0;
      shut_req_ff <= 1'b0;
    end else if (ce_i) begin
      if (wb_wr && wb_sel_i[0] && adr_is(wb_adr_i, ADR_CTRL) &&
          wb_dat_i[CTRL_INIT_BIT] && init_ok) begin
        init_req_ff <= 1'b1;
      end else if (init_take) begin
        init_req_ff <= 1'b0;
      end
      if (wb_wr && wb_sel_i[0] && adr_is(wb_adr_i, ADR_CTRL) &&
          wb_dat_i[CTRL_SHUT_BIT] && shut_ok) begin
        shut_req_ff <= 1'b1;
      end else if (shut_take) begin
        shut_req_ff <= 1'b0;
      end
    end
  end
  // free byte writes, allowed only once the display is on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      raw_req_ff  <= 1'b0;
      raw_sel_ff  <= 1'b0;
      raw_byte_ff <= 8'h00;
    end else if (ce_i) begin
      if (wb_wr && (wb_sel_i[1:0] == 2'b11) && adr_is(wb_adr_i, ADR_RAW) && raw_ok) begin
        raw_req_ff  <= 1'b1;  // RULE16
        raw_sel_ff  <= wb_dat_i[RAW_SEL_BIT];
        raw_byte_ff <= wb_dat_i[7:0];
      end else if (raw_take) begin
        raw_req_ff <= 1'b0;
      end
    end
  end

  // sticky refusal flag, write one to clear; a new refusal wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused_ff <= 1'b0;
    end else if (ce_i) begin
      if (wb_wr && wb_sel_i[0] &&
          ((adr_is(wb_adr_i, ADR_CTRL) &&
            ((wb_dat_i[CTRL_INIT_BIT] && !init_ok) ||
             (wb_dat_i[CTRL_SHUT_BIT] && !shut_ok))) ||
           (adr_is(wb_adr_i, ADR_RAW) && !raw_ok))) begin
        refused_ff <= 1'b1;  // RULE16
      end else if (wb_wr && wb_sel_i[0] && adr_is(wb_adr_i, ADR_STATUS) &&
                   wb_dat_i[ST_REFUSED]) begin
        refused_ff <= 1'b0;
      end
    end
  end

  // sequencer: reset pin, waits and ordered command writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff     <= S_OFF;
      step_ff      <= 4'h0;
      clear_n_ff   <= 1'b0;
      init_done_ff <= 1'b0;
      off_done_ff  <= 1'b0;
    end else if (ce_i) begin
      unique case (state_ff)
        S_OFF: begin
          clear_n_ff <= 1'b0;  // RULE1
          if (init_take) begin
            clear_n_ff  <= 1'b1;
            off_done_ff <= 1'b0;
            state_ff    <= S_REL_WAIT;
          end
        end
        S_REL_WAIT: begin
          if (tmr_done) begin
            step_ff  <= 4'h0;
            state_ff <= S_INIT_SEND;  // RULE2
          end
        end
        S_INIT_SEND: state_ff <= S_INIT_WAIT;
        S_INIT_WAIT: begin
          if (wr_done) begin
            if (step_ff == INIT_LAST) begin
              init_done_ff <= 1'b1;  // RULE17
              state_ff     <= S_READY;
            end else begin
              step_ff  <= step_ff + 4'h1;  // RULE16
              state_ff <= S_INIT_SEND;
            end
          end
        end
        S_READY: begin
          if (raw_take) begin
            state_ff <= S_RAW_WAIT;
          end else if (shut_take) begin
            init_done_ff <= 1'b0;
            step_ff      <= 4'h0;
            state_ff     <= S_SHUT_SEND;
          end
        end
        S_RAW_WAIT: begin
          if (wr_done) begin
            state_ff <= S_READY;
          end
        end
        S_SHUT_SEND: state_ff <= S_SHUT_WAIT;
        S_SHUT_WAIT: begin
          if (wr_done) begin
            if (step_ff == SHUT_LAST) begin
              clear_n_ff <= 1'b0;  // RULE12
              state_ff   <= S_OFF_WAIT;
            end else begin
              step_ff  <= step_ff + 4'h1;
              state_ff <= S_SHUT_SEND;
            end
          end
        end
        S_OFF_WAIT: begin
          if (tmr_done) begin
            off_done_ff <= 1'b1;  // RULE17
            state_ff    <= S_OFF_DONE;
          end
        end
        S_OFF_DONE: begin
          if (init_req_ff) begin
            state_ff <= S_OFF;
          end
        end
      endcase
    end
  end
  // byte to send and when to start it
  always_comb begin
    wr_start = 1'b0;
    wr_dsel  = 1'b0;  // RULE13
    wr_byte  = 8'h00;
    unique case (state_ff)
      S_INIT_SEND: begin
        wr_start = 1'b1;
        wr_byte  = init_byte(step_ff, boost5_ff, contrast_ff);
      end
      S_SHUT_SEND: begin
        wr_start = 1'b1;
        wr_byte  = (step_ff == 4'h0) ? CMD_DISP_OFF : CMD_ALL_ON;  // RULE11
      end
      S_READY: begin
        wr_start = raw_take;
        wr_dsel  = raw_sel_ff;
        wr_byte  = raw_byte_ff;
      end
      default: wr_start = 1'b0;
    endcase
  end
  // timer loads on entry to the two waits
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = TIMER_W'(RELEASE_CYC);
    if (init_take) begin
      tmr_load  = 1'b1;
      tmr_count = TIMER_W'(RELEASE_CYC);  // RULE2
    end else if (state_ff == S_SHUT_WAIT && wr_done && step_ff == SHUT_LAST) begin
      tmr_load  = 1'b1;
      tmr_count = TIMER_W'(OFF_WAIT_CYC);  // RULE12
    end
  end
  lcd_wait_timer #(.W (TIMER_W)) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .load_i  (tmr_load),
    .count_i (tmr_count),
    .done_o  (tmr_done)
  );
  lcd_byte_writer u_writer (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .ce_i           (ce_i),
    .start_i        (wr_start),
    .dsel_i         (wr_dsel),
    .byte_i         (wr_byte),
    .busy_o         (wr_busy),
    .done_o         (wr_done),
    .cmd_data_sel_o (lcd_o.cmd_data_sel),
    .cs_n_o         (lcd_o.cs_n),
    .wr_n_o         (lcd_o.wr_n),
    .data_o         (lcd_o.data),
    .data_oe_o      (lcd_o.data_oe)
  );
  // pins and status outputs
  assign lcd_o.chip_clear_n = clear_n_ff;
  assign lcd_o.rd_n         = 1'b1;  // RULE13
  assign init_done_o        = init_done_ff;
  assign off_done_o         = off_done_ff;
endmodule : lcd_power_init_sequencer

// ===== verification/lcd_power_init_sequencer_sva.sv
`timescale 1ns/1ps
module lcd_seq_sva
  import lcd_seq_pkg::*;
#(
  parameter int OFF_WAIT_CYC = OFF_CYC
) (
  input wire logic      clk_i,
  input wire logic      rst_i,
  input wire logic      ce_i,
  input wire logic      power_good_i,
  input wire logic      wb_cyc_i,
  input wire logic      wb_stb_i,
  input wire logic      wb_ack_o,
  input wire lcd_pins_t lcd_o,
  input wire logic      init_done_o,
  input wire logic      off_done_o
);
  int         up_ff;
  int         low_ff;
  logic [7:0] last_ff;
  // cycles spent out of and in chip clear, saturating
  always_ff @(posedge clk_i) begin
    if (!lcd_o.chip_clear_n) up_ff <= 0;
    else if (up_ff < 1000) up_ff <= up_ff + 1;
  end
  always_ff @(posedge clk_i) begin
    if (lcd_o.chip_clear_n) low_ff <= 0;
    else if (low_ff < OFF_WAIT_CYC + 2) low_ff <= low_ff + 1;
  end
  // byte on the pins while the strobe is low
  always_ff @(posedge clk_i) begin
    if (!lcd_o.wr_n) last_ff <= lcd_o.data;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  sequence s_strobe2;
    !lcd_o.wr_n ##1 !lcd_o.wr_n;
  endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  property p_ack_one; wb_ack_o && ce_i |=> !wb_ack_o; endproperty
  property p_rd; lcd_o.rd_n; endproperty
  property p_strobe; !lcd_o.wr_n |-> !lcd_o.cs_n && lcd_o.data_oe && lcd_o.chip_clear_n;
  endproperty
  property p_cmd; !lcd_o.wr_n && !init_done_o |-> !lcd_o.cmd_data_sel; endproperty
  property p_hold; s_strobe2 |-> $stable(lcd_o.data); endproperty
  property p_release; !lcd_o.wr_n |-> up_ff >= RELEASE_CYC; endproperty
  property p_pg; !power_good_i [*4] ##0 !lcd_o.chip_clear_n |=> !lcd_o.chip_clear_n;
  endproperty
  property p_off; $rose(off_done_o) |-> low_ff >= OFF_WAIT_CYC; endproperty
  property p_done; $rose(init_done_o) |-> last_ff == CMD_DISP_ON; endproperty

  a_ack: assert property (p_ack) else $error("no ack after request");
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  a_rd: assert property (p_rd) else $error("read strobe active");
  a_strobe: assert property (p_strobe) else $error("strobe outside select");
  a_cmd: assert property (p_cmd) else $error("data write before ready");
  a_hold: assert property (p_hold) else $error("byte moved under strobe");
  a_release: assert property (p_release) else $error("write too soon");
  a_pg: assert property (p_pg) else $error("clear released early");
  a_off: assert property (p_off) else $error("off done too soon");
  a_done: assert property (p_done) else $error("done without display on");
endmodule : lcd_seq_sva

bind lcd_power_init_sequencer lcd_seq_sva #(.OFF_WAIT_CYC(OFF_WAIT_CYC)) u_sva (
  .clk_i, .rst_i, .ce_i, .power_good_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .lcd_o,
  .init_done_o, .off_done_o);

// ===== verification/lcd_panel_model.sv
`timescale 1ns/1ps
module lcd_panel_model
  import lcd_seq_pkg::*;
(
  input  wire logic      clk_i,
  input  wire lcd_pins_t pins_i,
  output logic           got_o,
  output logic [8:0]     word_o,
  output logic [2:0]     power_o,
  output logic [5:0]     level_o
);
  logic wr_ff;
  logic vol_ff;
  // a write lands at the trailing edge of the strobe
  always_ff @(posedge clk_i) begin
    wr_ff <= pins_i.wr_n;
    got_o <= 1'b0;
    if (!wr_ff && pins_i.wr_n && !pins_i.cs_n && pins_i.rd_n) begin
      got_o  <= 1'b1;
      word_o <= {pins_i.cmd_data_sel, pins_i.data};
    end
  end
  // command decode; chip clear wipes the state
  always_ff @(posedge clk_i) begin
    if (!pins_i.chip_clear_n) begin
      power_o <= 3'h0;
      vol_ff  <= 1'b0;
      level_o <= 6'h20;
    end else if (got_o && !word_o[8]) begin
      vol_ff <= (word_o[7:0] == CMD_VOL_MODE);
      if (vol_ff) level_o <= word_o[5:0];
      else if (word_o[7:3] == 5'h05) power_o <= word_o[2:0];
    end
  end
endmodule : lcd_panel_model

// ===== verification/lcd_power_init_sequencer_tb.sv
`timescale 1ns/1ps
module lcd_power_init_sequencer_tb;
  import lcd_seq_pkg::*;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        pg   = 1'b0;
  logic        ce   = 1'b1;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic        we   = 1'b0;
  logic [3:0]  adr  = 4'h0;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  lcd_pins_t   pins;
  logic        idone;
  logic        odone;
  logic        got;
  logic [8:0]  word;
  logic [2:0]  pwr;
  logic [5:0]  lvl_seen;
  logic [31:0] rd_v;
  logic [5:0]  lvl;
  logic [7:0]  d;
  logic [8:0]  ew;
  logic [7:0]  sq [12];
  logic [8:0]  exp_q [$];
  int          n_fail = 0;
  int          n_checks = 0;
  int          seed = 32'h6f8d;

  lcd_power_init_sequencer #(.OFF_WAIT_CYC(200)) uut (
    .clk_i(clk), .rst_i(rst), .ce_i(ce), .power_good_i(pg), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .lcd_o(pins), .init_done_o(idone), .off_done_o(odone));
  lcd_panel_model u_panel (
    .clk_i(clk), .pins_i(pins), .got_o(got), .word_o(word), .power_o(pwr), .level_o(lvl_seen));

  initial begin
    forever #10 clk = ~clk;
  end

  task stop_test;
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // one classic wishbone cycle, held until ack is sampled
  task wb(input logic w, input logic [3:0] a, input logic [31:0] dv);
    int i;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hf; wdat <= dv;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin n_fail++; stop_test(); end
    rd_v = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  // bounded wait: 0 init done, 1 off done, 2 all bytes seen
  task wait_on(input int m);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (m == 0 && idone === 1'b1) break;
      if (m == 1 && odone === 1'b1) break;
      if (m == 2 && exp_q.size() == 0) break;
    end
    if (i == 3000) begin n_fail++; stop_test(); end
  endtask : wait_on

  // every byte on the pins is matched against the oldest note
  always @(posedge clk) begin
    if (got === 1'b1) begin
      ew = exp_q.size() ? exp_q.pop_front() : 'x;
      chk("byte", ew, word);
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(0, ADR_STATUS, 0);
    chk("status", 0, rd_v);
    wb(0, ADR_CONTRAST, 0);
    chk("contrast", 32'h1b, rd_v);
    wb(1, ADR_CTRL, 2);
    wb(0, ADR_STATUS, 0);
    chk("refused", 32'h8, rd_v & 32'h8);
    wb(1, ADR_STATUS, 8);
    wb(0, ADR_STATUS, 0);
    chk("refused clr", 0, rd_v & 32'h8);
    wb(1, 4'h2, 32'h5a);
    wb(0, 4'h2, 0);
    chk("unmapped", 0, rd_v);
    wb(1, ADR_RAW, 32'h155); // refused before ready: no byte expected
    wb(0, ADR_STATUS, 0);
    chk("raw refused", 32'h8, rd_v & 32'h8);
    wb(1, ADR_STATUS, 8);
    for (int p = 0; p < 2; p++) begin
      lvl = 6'($random(seed));
      wb(1, ADR_CONTRAST, {26'h0, lvl});
      sq = '{CMD_BIAS_1_9, CMD_SEG_NORMAL, CMD_COM_REVERSE, CMD_BOOST_MODE,
             p ? CMD_BOOST_5X : CMD_BOOST_4X, CMD_REG_RATIO, CMD_VOL_MODE, {2'h0, lvl},
             CMD_PWR_BOOST, CMD_PWR_REG, CMD_PWR_FOLLOW, CMD_DISP_ON};
      foreach (sq[i]) exp_q.push_back({1'b0, sq[i]});
      wb(1, ADR_CTRL, (p << 2) | 1);
      if (p == 0) begin
        repeat (20) @(posedge clk);
        chk("clear held", 0, pins.chip_clear_n);
        ce <= 1'b0;
        pg <= 1'b1;
        repeat (10) @(posedge clk);
        chk("frozen clear", 0, pins.chip_clear_n);
        ce <= 1'b1;
      end
      wait_on(0);
      wait_on(2);
      chk("power", 7, pwr);
      chk("level", lvl, lvl_seen);
      wb(0, ADR_STATUS, 0);
      chk("status on", 32'hb11, rd_v);
      d = 8'($random(seed));
      exp_q.push_back({1'b1, d});
      wb(1, ADR_RAW, {23'h0, 1'b1, d});
      wait_on(2);
      exp_q.push_back({1'b0, CMD_DISP_OFF});
      exp_q.push_back({1'b0, CMD_ALL_ON});
      wb(1, ADR_CTRL, 2);
      wait_on(1);
      wait_on(2);
      chk("init done", 0, idone);
      chk("clear low", 0, pins.chip_clear_n);
      wb(0, ADR_STATUS, 0);
      chk("status off", 32'h112, rd_v);
    end
    stop_test();
  end
endmodule : lcd_power_init_sequencer_tb
